// File: bcp_pkg.sv
// Constants shared by the bias channel power and trigger register bank
// Function
// - Status bits 15:8 show each channel's effective switch drive enable.
// - Status bits 7:0 show each channel's power state.
// - Power enable bit 8 is the read-write amplifier-on enable.
// - Alarm turning amplifier output off leaves its enable bit at one.
// - Power enable bits 7:0 enable channels; reset 0200h, bit 9 reads one.
// - Trigger bit 2 clears alarm latches, self-clears; zero does nothing.
// - Alarm still present at clear sets its latch again at once.
// - Trigger bit 1 copies buffered codes to active codes; self-clears.
// - Trigger bit 0 starts conversions; direct mode clears when all done.
// - Auto mode keeps start bit set; host writes zero to stop.
// - Reading pin data bit 0 returns the sampled multifunction pin level.
// - Pin data zero drives low; one drives high or releases; reset 0001h.
// - Software enable bits 7:0 give channels software switch control; reset 00FFh.
// - Software drive value acts only under software control; zero ties low.
// - Switched outputs at zero go to supply or neighbour per clamp select.
// - Broadcast code write loads buffer and active codes of enabled channels.
// - Config bit 1 forces converter results to the stored bypass value.
// - Config bit 0 bypasses all alarm states and alarm status bits.
package bcp_pkg;

  localparam int NUM_CH     = 8;
  localparam int ADDR_W     = 7;
  localparam int DATA_W     = 16;
  localparam int CODE_W     = 13;
  localparam int NUM_ALARMS = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CHANNEL_POWER_STATUS = 7'h07;
  localparam logic [ADDR_W-1:0] OFF_POWER_ENABLE         = 7'h08;
  localparam logic [ADDR_W-1:0] OFF_TRIGGER_STROBES      = 7'h10;
  localparam logic [ADDR_W-1:0] OFF_GENERAL_PIN_DATA     = 7'h11;
  localparam logic [ADDR_W-1:0] OFF_SWITCH_SW_ENABLE     = 7'h12;
  localparam logic [ADDR_W-1:0] OFF_SWITCH_SW_VALUE      = 7'h13;
  localparam logic [ADDR_W-1:0] OFF_BROADCAST_CODE       = 7'h14;
  localparam logic [ADDR_W-1:0] OFF_GLOBAL_BYPASS_CONFIG = 7'h17;

  // Field positions
  localparam int POS_AMP_ON_ENABLE   = 8;
  localparam int POS_DRIVE_STATUS    = 8;
  localparam int POS_ALARM_CLEAR     = 2;
  localparam int POS_CODE_LOAD       = 1;
  localparam int POS_CONV_START      = 0;
  localparam int POS_RESULT_BYPASS   = 1;
  localparam int POS_ALARM_BYPASS    = 0;

  // Reset values and read-only fixed patterns
  localparam logic [DATA_W-1:0] RST_POWER_ENABLE    = 16'h0200;
  localparam logic [DATA_W-1:0] FIXED_POWER_ENABLE  = 16'h0200;
  localparam logic [DATA_W-1:0] RST_PIN_DATA        = 16'h0001;
  localparam logic [DATA_W-1:0] RST_SW_ENABLE       = 16'h00ff;
  localparam logic [DATA_W-1:0] RST_SW_VALUE        = 16'h0000;
  localparam logic [DATA_W-1:0] RST_GLOBAL_CONFIG   = 16'h0000;
  localparam logic [DATA_W-1:0] RST_READ_DATA       = 16'h0000;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

endpackage : bcp_pkg

// File: bcp_sync_if.sv
// Bundle carrying raw pin levels into the synchroniser and clean levels out
`timescale 1ns/1ns
interface bcp_sync_if #(
  parameter int WIDTH = 1
);
  logic [WIDTH-1:0] raw_level;
  logic [WIDTH-1:0] clean_level;

  modport sink (input raw_level, output clean_level);
  modport source (output raw_level, input clean_level);
endinterface : bcp_sync_if

// File: bcp_pin_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module bcp_pin_sync
  import bcp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic  sys_clk,
  input  wire logic  srst,
  bcp_sync_if.sink   pins
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] clean_reg;

  // First stage feeds only the second; nothing else samples it
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_reg  <= '0;
      clean_reg <= '0;
    end else begin
      meta_reg  <= pins.raw_level;
      clean_reg <= meta_reg;
    end
  end

  assign pins.clean_level = clean_reg;

endmodule : bcp_pin_sync

// File: bcp_regs.sv
// Global-page power, switch and trigger register bank for eight bias channels
`timescale 1ns/1ns
module bcp_regs
  import bcp_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic [DATA_W-1:0]     reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [DATA_W-1:0]     reg_rdata,
  output logic                       reg_rvalid,
  input  wire logic [NUM_CH-1:0]     drive_pin_async,
  input  wire logic                  multipin_in,
  input  wire logic                  multipin_open_drain,
  output logic                       multipin_out,
  output logic                       multipin_oe_n,
  input  wire logic                  amp_alarm_off,
  output logic                       amplifier_on_output,
  output logic                       amplifier_on_status,
  input  wire logic [NUM_ALARMS-1:0] alarm_condition,
  output logic [NUM_ALARMS-1:0]      alarm_latched,
  output logic                       alarm_latch_clear,
  output logic                       code_load_strobe,
  input  wire logic [NUM_CH-1:0]     broadcast_enable,
  output logic [NUM_CH-1:0]          broadcast_load,
  output logic [CODE_W-1:0]          broadcast_data,
  input  wire logic                  conv_auto_mode,
  input  wire logic                  conv_all_done,
  output logic                       conversion_start,
  output logic                       result_bypass_enable,
  output logic                       alarm_bypass_enable,
  output logic [NUM_CH-1:0]          channel_power_on,
  output logic [NUM_CH-1:0]          switch_drive_enable,
  input  wire logic [3:0]            switched_clamp_select,
  output logic [3:0]                 switched_to_neighbour
);

  // Software-visible state
  logic [NUM_CH-1:0]     power_enable_reg;
  logic [NUM_CH-1:0]     power_enable_next;
  logic                  amp_en_reg;
  logic                  amp_en_next;
  logic                  pin_data_reg;
  logic                  pin_data_next;
  logic [NUM_CH-1:0]     sw_en_reg;
  logic [NUM_CH-1:0]     sw_en_next;
  logic [NUM_CH-1:0]     sw_val_reg;
  logic [NUM_CH-1:0]     sw_val_next;
  logic [1:0]            gcfg_reg;
  logic [1:0]            gcfg_next;
  logic                  conv_reg;
  logic                  conv_next;
  logic [NUM_ALARMS-1:0] alarm_reg;
  logic [NUM_ALARMS-1:0] alarm_next;

  // Synchronised pin levels
  logic [NUM_CH-1:0] drive_pin_sync;
  logic              multipin_sync;

  bcp_sync_if #(.WIDTH(NUM_CH + 1)) pin_bus ();

  assign pin_bus.raw_level = {multipin_in, drive_pin_async};
  assign drive_pin_sync    = pin_bus.clean_level[NUM_CH-1:0];
  assign multipin_sync     = pin_bus.clean_level[NUM_CH];

  bcp_pin_sync #(.WIDTH(NUM_CH + 1)) u_pin_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .pins    (pin_bus)
  );

  // Address decode
  wire wr_pwr   = reg_wr && (reg_addr == OFF_POWER_ENABLE);
  wire wr_trig  = reg_wr && (reg_addr == OFF_TRIGGER_STROBES);
  wire wr_pin   = reg_wr && (reg_addr == OFF_GENERAL_PIN_DATA);
  wire wr_swen  = reg_wr && (reg_addr == OFF_SWITCH_SW_ENABLE);
  wire wr_swval = reg_wr && (reg_addr == OFF_SWITCH_SW_VALUE);
  wire wr_bcast = reg_wr && (reg_addr == OFF_BROADCAST_CODE);
  wire wr_gcfg  = reg_wr && (reg_addr == OFF_GLOBAL_BYPASS_CONFIG);

  // Trigger bits 2 and 1 acted on only when written as one; bit 0 also acts on zero
  // clear on one
  wire clr_hit   = wr_trig && reg_wdata[POS_ALARM_CLEAR];
  wire load_hit  = wr_trig && reg_wdata[POS_CODE_LOAD];
  wire conv_wr1  = wr_trig && reg_wdata[POS_CONV_START];
  wire conv_wr0  = wr_trig && !reg_wdata[POS_CONV_START];

  // Next values of writable fields; reserved bits are never stored
  // reserved bits dropped
  assign power_enable_next   = wr_pwr ? reg_wdata[NUM_CH-1:0] : power_enable_reg;
  assign amp_en_next   = wr_pwr ? reg_wdata[POS_AMP_ON_ENABLE] : amp_en_reg;
  assign pin_data_next = wr_pin ? reg_wdata[0] : pin_data_reg;
  assign sw_en_next    = wr_swen ? reg_wdata[NUM_CH-1:0] : sw_en_reg;
  assign sw_val_next   = wr_swval ? reg_wdata[NUM_CH-1:0] : sw_val_reg;
  assign gcfg_next     = wr_gcfg ? reg_wdata[1:0] : gcfg_reg;

  // Conversion start: set by host, cleared by host or by direct-mode finish
  // direct mode self-clear
  wire conv_done_clr = conv_all_done && !conv_auto_mode;
  // auto mode holds until host zero
  assign conv_next = conv_wr1 ? 1'b1
                   : (conv_wr0 || conv_done_clr) ? 1'b0
                   : conv_reg;

  // Alarm latches; bypass hides every condition
  // bypass masks alarms
  wire [NUM_ALARMS-1:0] alarm_live =
    gcfg_reg[POS_ALARM_BYPASS] ? '0 : alarm_condition;
  assign alarm_next = gcfg_reg[POS_ALARM_BYPASS] ? '0
                    : clr_hit ? alarm_live
                    : (alarm_reg | alarm_live);

  // Effective drive: software value or the external switch pin
  // software value under control
  wire [NUM_CH-1:0] drive_eff =
    (sw_en_reg & sw_val_reg) | (~sw_en_reg & drive_pin_sync);

  // Switched outputs are channels 0 and 2 of each group
  wire [3:0] switched_drive = {drive_eff[6], drive_eff[4],
                               drive_eff[2], drive_eff[0]};
  wire [3:0] neighbour_next = ~switched_drive & switched_clamp_select;

  // Open-drain releases the pin for a one; push-pull drives it
  // pin drive mode
  wire pin_out_next  = multipin_open_drain ? 1'b0 : pin_data_reg;
  wire pin_oe_n_next = multipin_open_drain ? pin_data_reg : 1'b0;

  wire amp_on_next = amp_en_reg && !amp_alarm_off;

  // Read data selection
  // drive status high byte
  wire [DATA_W-1:0] rd_status = {drive_eff, power_enable_reg};
  wire [DATA_W-1:0] rd_pwr =
    FIXED_POWER_ENABLE | {7'h00, amp_en_reg, power_enable_reg};
  wire [DATA_W-1:0] rd_trig = {15'h0000, conv_reg};
  wire [DATA_W-1:0] rd_pin  = {15'h0000, multipin_sync};
  wire [DATA_W-1:0] rd_swen  = {8'h00, sw_en_reg};
  wire [DATA_W-1:0] rd_swval = {8'h00, sw_val_reg};
  wire [DATA_W-1:0] rd_gcfg  = {14'h0000, gcfg_reg};

  logic [DATA_W-1:0] rd_mux;

  // Unmapped and write-only offsets read as zero
  always_comb begin
    case (reg_addr)
      OFF_CHANNEL_POWER_STATUS: rd_mux = rd_status;
      OFF_POWER_ENABLE:         rd_mux = rd_pwr;
      OFF_TRIGGER_STROBES:      rd_mux = rd_trig;
      OFF_GENERAL_PIN_DATA:     rd_mux = rd_pin;
      OFF_SWITCH_SW_ENABLE:     rd_mux = rd_swen;
      OFF_SWITCH_SW_VALUE:      rd_mux = rd_swval;
      OFF_GLOBAL_BYPASS_CONFIG: rd_mux = rd_gcfg;
      default:                  rd_mux = RST_READ_DATA;
    endcase
  end

  // Configuration and control registers
  // channel enables and reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      power_enable_reg   <= RST_POWER_ENABLE[NUM_CH-1:0];
      amp_en_reg   <= RST_POWER_ENABLE[POS_AMP_ON_ENABLE];
      pin_data_reg <= RST_PIN_DATA[0];
      sw_en_reg    <= RST_SW_ENABLE[NUM_CH-1:0];
      sw_val_reg   <= RST_SW_VALUE[NUM_CH-1:0];
      gcfg_reg     <= RST_GLOBAL_CONFIG[1:0];
    end else begin
      power_enable_reg   <= power_enable_next;
      amp_en_reg   <= amp_en_next;
      pin_data_reg <= pin_data_next;
      sw_en_reg    <= sw_en_next;
      sw_val_reg   <= sw_val_next;
      gcfg_reg     <= gcfg_next;
    end
  end

  // Conversion state and alarm latches
  // start bit register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conv_reg  <= 1'b0;
      alarm_reg <= '0;
    end else begin
      conv_reg  <= conv_next;
      alarm_reg <= alarm_next;
    end
  end

  // One-cycle strobes; trigger bits 2 and 1 never hold their written ones
  // load strobe pulse
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      alarm_latch_clear <= 1'b0;
      code_load_strobe  <= 1'b0;
      broadcast_load    <= '0;
      broadcast_data    <= '0;
    end else begin
      alarm_latch_clear <= clr_hit;
      code_load_strobe  <= load_hit;
      broadcast_load    <= wr_bcast ? broadcast_enable : '0;
      if (wr_bcast) begin
        broadcast_data <= reg_wdata[CODE_W-1:0];
      end
    end
  end

  // Registered drive outputs toward the analog switches and pins
  // result bypass output
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      channel_power_on      <= '0;
      switch_drive_enable   <= '0;
      switched_to_neighbour <= '0;
      multipin_out          <= 1'b0;
      multipin_oe_n         <= 1'b1;
      amplifier_on_output   <= 1'b0;
      amplifier_on_status   <= 1'b0;
      result_bypass_enable  <= 1'b0;
      alarm_bypass_enable   <= 1'b0;
      conversion_start      <= 1'b0;
      alarm_latched         <= '0;
    end else begin
      channel_power_on      <= power_enable_reg;
      switch_drive_enable   <= drive_eff;
      switched_to_neighbour <= neighbour_next;
      multipin_out          <= pin_out_next;
      multipin_oe_n         <= pin_oe_n_next;
      amplifier_on_output   <= amp_on_next;
      amplifier_on_status   <= amp_on_next;
      result_bypass_enable  <= gcfg_reg[POS_RESULT_BYPASS];
      alarm_bypass_enable   <= gcfg_reg[POS_ALARM_BYPASS];
      conversion_start      <= conv_reg;
      alarm_latched         <= alarm_reg;
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata  <= RST_READ_DATA;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

endmodule : bcp_regs

// File: bcp_regs_properties.sv
// Port-level checks for the bias channel register bank
`timescale 1ns/1ns
module bcp_regs_properties
  import bcp_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  srst,
  input wire logic [ADDR_W-1:0]     reg_addr,
  input wire logic [DATA_W-1:0]     reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  amp_alarm_off,
  input wire logic                  amplifier_on_output,
  input wire logic [NUM_ALARMS-1:0] alarm_condition,
  input wire logic [NUM_ALARMS-1:0] alarm_latched,
  input wire logic                  code_load_strobe,
  input wire logic                  conv_auto_mode,
  input wire logic                  conv_all_done,
  input wire logic                  conversion_start,
  input wire logic                  alarm_bypass_enable,
  input wire logic [NUM_CH-1:0]     channel_power_on,
  input wire logic [NUM_CH-1:0]     switch_drive_enable,
  input wire logic [3:0]            switched_clamp_select,
  input wire logic [3:0]            switched_to_neighbour
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // Decoded host writes and the wanted clamp routing
  wire              trig_wr  = reg_wr && reg_addr == OFF_TRIGGER_STROBES;
  wire              load_wr  = trig_wr && reg_wdata[POS_CODE_LOAD];
  wire              start_wr = trig_wr && reg_wdata[POS_CONV_START];
  wire              pwr_wr   = reg_wr && reg_addr == OFF_POWER_ENABLE;
  wire [NUM_CH-1:0] pwr_bits = reg_wdata[NUM_CH-1:0];
  wire [3:0]        nb_want  = switched_clamp_select & ~{switch_drive_enable[6],
    switch_drive_enable[4], switch_drive_enable[2], switch_drive_enable[0]};

  // Idle bus in auto mode, then a running conversion
  sequence auto_run;
    conv_auto_mode && !reg_wr ##1 conversion_start;
  endsequence
  // Completion in direct mode, no start write racing it
  sequence direct_done;
    conv_all_done && !conv_auto_mode && !start_wr;
  endsequence

  chk_load_fires: assert property (load_wr |=> code_load_strobe)
    else $error("load strobe missing");
  chk_load_cause: assert property (code_load_strobe |-> $past(load_wr))
    else $error("load strobe without write");
  // live alarm relatches, two register stages behind the condition
  chk_latch_holds: assert property (
    !alarm_bypass_enable && !reg_wr && !$past(reg_wr) ##1 !reg_wr |->
    ##1 (alarm_latched & $past(alarm_condition, 2))
    == $past(alarm_condition, 2))
    else $error("live alarm not latched");
  chk_bypass_zero: assert property (
    alarm_bypass_enable [*2] |-> alarm_latched == 8'h00)
    else $error("latch set under bypass");
  chk_amp_off: assert property (amp_alarm_off |=> !amplifier_on_output)
    else $error("amplifier on during alarm");
  chk_power_out: assert property (
    pwr_wr |-> ##2 channel_power_on == $past(pwr_bits, 2))
    else $error("power outputs wrong");
  chk_start_set: assert property (start_wr |-> ##2 conversion_start)
    else $error("start bit not set");
  chk_start_done: assert property (direct_done |-> ##2 !conversion_start)
    else $error("start bit not cleared");
  chk_auto_hold: assert property (auto_run |=> conversion_start)
    else $error("auto conversion stopped");
  // clamp routing, judged once inputs settle
  chk_neigh_route: assert property (
    $stable(switch_drive_enable) && $stable(switched_clamp_select)
    && !$past(srst) |-> switched_to_neighbour == nb_want)
    else $error("clamp routing wrong");
endmodule : bcp_regs_properties

bind bcp_regs bcp_regs_properties i_bcp_regs_properties (.*);

// File: bcp_host_model.sv
// Host processor model issuing word reads and writes
`timescale 1ns/1ns
module bcp_host_model
  import bcp_pkg::*;
(
  input  wire logic              sys_clk,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [DATA_W-1:0] reg_wdata,
  output logic                   reg_wr,
  output logic                   reg_rd,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic              reg_rvalid
);
  // Quiet bus at time zero
  initial begin
    reg_addr  = 7'h7f;
    reg_wdata = 16'hffff;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One strobe per word; idle bus shows inverted values, never stale ones
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic v);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = w;
    reg_rd    = !w;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
    // Valid stands only one cycle after the strobe edge, so take it now
    q = reg_rdata;
    v = reg_rvalid;
  endtask : xfer
endmodule : bcp_host_model

// File: test_bcp_regs.sv
// Self-checking bench for the bias channel register bank
`timescale 1ns/1ns
module test_bcp_regs
  import bcp_pkg::*;
();
  logic                  sys_clk = 1'b0;
  logic                  srst = 1'b1;
  logic [ADDR_W-1:0]     reg_addr;
  logic [DATA_W-1:0]     reg_wdata, reg_rdata, q, d;
  logic                  reg_wr, reg_rd, reg_rvalid, v, multipin_in;
  logic                  multipin_open_drain, multipin_out, multipin_oe_n;
  logic                  amp_alarm_off, amplifier_on_output;
  logic                  amplifier_on_status, alarm_latch_clear;
  logic                  code_load_strobe, conv_auto_mode, conv_all_done;
  logic                  conversion_start, result_bypass_enable;
  logic                  alarm_bypass_enable;
  logic [NUM_CH-1:0]     drive_pin_async, broadcast_enable, broadcast_load;
  logic [NUM_CH-1:0]     channel_power_on, switch_drive_enable, en, val, pw;
  logic [NUM_ALARMS-1:0] alarm_condition, alarm_latched;
  logic [CODE_W-1:0]     broadcast_data;
  logic [3:0]            switched_clamp_select, switched_to_neighbour;
  int                    n_fail = 0;
  int                    total_checks = 0;
  int                    seed = 37150;

  bcp_regs i_bcp_regs (.*);
  bcp_host_model i_bcp_host_model (.*);

  // Free-running 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] e);
    total_checks++;
    if (got !== e) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, e);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    i_bcp_host_model.xfer(1'b1, a, x, q, v);
  endtask : wr

  // Read answers one cycle later with a valid pulse
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    i_bcp_host_model.xfer(1'b0, a, 16'h0000, q, v);
    chk({15'h0000, v}, 16'h0001);
    chk(q, e);
  endtask : rd

  task automatic done_pulse;
    conv_all_done = 1'b1;
    @(negedge sys_clk);
    conv_all_done = 1'b0;
  endtask : done_pulse

  // Software value where enabled, else the external pin
  function automatic logic [NUM_CH-1:0] drv(input logic [NUM_CH-1:0] e,
    input logic [NUM_CH-1:0] s, input logic [NUM_CH-1:0] p);
    return (e & s) | (~e & p);
  endfunction : drv

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (8000) @(posedge sys_clk);
    n_fail++;
    give_verdict;
  end

  initial begin
    {amp_alarm_off, conv_auto_mode, conv_all_done, multipin_open_drain} = 4'h0;
    {drive_pin_async, alarm_condition, broadcast_enable} = 24'h000000;
    switched_clamp_select = 4'h0;
    multipin_in = 1'b1;
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
    // Reset values, plus an unmapped word
    rd(OFF_POWER_ENABLE, RST_POWER_ENABLE);
    rd(OFF_GENERAL_PIN_DATA, RST_PIN_DATA);
    rd(OFF_SWITCH_SW_ENABLE, RST_SW_ENABLE);
    rd(OFF_SWITCH_SW_VALUE, RST_SW_VALUE);
    rd(OFF_GLOBAL_BYPASS_CONFIG, RST_GLOBAL_CONFIG);
    rd(OFF_CHANNEL_POWER_STATUS, 16'h0000);
    rd(7'h20, 16'h0000);
    $display("reset test done");
    // Random enables and pins; first pass puts all channels on pins
    for (int i = 0; i < 24; i++) begin
      {en, val, pw} = 24'($random(seed));
      drive_pin_async = 8'($random(seed));
      switched_clamp_select = 4'($random(seed));
      if (i == 0) en = 8'h00;
      wr(OFF_POWER_ENABLE, {7'h7f, i[0], pw});
      wr(OFF_SWITCH_SW_ENABLE, {8'hff, en});
      wr(OFF_SWITCH_SW_VALUE, {8'ha5, val});
      repeat (4) @(negedge sys_clk);
      rd(OFF_POWER_ENABLE, {7'h01, i[0], pw});
      rd(OFF_SWITCH_SW_ENABLE, {8'h00, en});
      rd(OFF_SWITCH_SW_VALUE, {8'h00, val});
      rd(OFF_CHANNEL_POWER_STATUS, {drv(en, val, drive_pin_async), pw});
      chk({8'h00, switch_drive_enable}, {8'h00, drv(en, val, drive_pin_async)});
      chk({15'h0000, amplifier_on_output}, {15'h0000, i[0]});
    end
    $display("switch test done");
    // Alarm drops the amplifier while its enable stays
    wr(OFF_POWER_ENABLE, 16'h0100);
    amp_alarm_off = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk({15'h0000, amplifier_on_status}, 16'h0000);
    rd(OFF_POWER_ENABLE, 16'h0300);
    amp_alarm_off = 1'b0;
    // Load strobe, then direct and auto conversions
    wr(OFF_TRIGGER_STROBES, 16'h0002);
    chk({15'h0000, code_load_strobe}, 16'h0001);
    wr(OFF_TRIGGER_STROBES, 16'h0001);
    rd(OFF_TRIGGER_STROBES, 16'h0001);
    done_pulse;
    rd(OFF_TRIGGER_STROBES, 16'h0000);
    conv_auto_mode = 1'b1;
    wr(OFF_TRIGGER_STROBES, 16'h0001);
    done_pulse;
    rd(OFF_TRIGGER_STROBES, 16'h0001);
    wr(OFF_TRIGGER_STROBES, 16'h0000);
    rd(OFF_TRIGGER_STROBES, 16'h0000);
    conv_auto_mode = 1'b0;
    $display("trigger test done");
    // Clear drops gone alarms, keeps live ones; bypass empties all
    alarm_condition = 8'h05;
    @(negedge sys_clk);
    alarm_condition = 8'h01;
    wr(OFF_TRIGGER_STROBES, 16'h0004);
    chk({15'h0000, alarm_latch_clear}, 16'h0001);
    repeat (2) @(negedge sys_clk);
    chk({8'h00, alarm_latched}, 16'h0001);
    wr(OFF_GLOBAL_BYPASS_CONFIG, 16'hffff);
    repeat (3) @(negedge sys_clk);
    chk({8'h00, alarm_latched}, 16'h0000);
    chk({14'h0000, result_bypass_enable, alarm_bypass_enable}, 16'h0003);
    rd(OFF_GLOBAL_BYPASS_CONFIG, 16'h0003);
    wr(OFF_GLOBAL_BYPASS_CONFIG, 16'h0000);
    alarm_condition = 8'h00;
    $display("alarm test done");
    // Broadcast reaches enabled channels only
    broadcast_enable = 8'($random(seed));
    d = 16'($random(seed));
    wr(OFF_BROADCAST_CODE, d);
    chk({8'h00, broadcast_load}, {8'h00, broadcast_enable});
    chk({3'h0, broadcast_data}, {3'h0, d[12:0]});
    rd(OFF_BROADCAST_CODE, 16'h0000);
    // Pin drive in both output modes, and its sampled level
    for (int m = 0; m < 4; m++) begin
      multipin_open_drain = m[1];
      multipin_in = m[1];
      wr(OFF_GENERAL_PIN_DATA, {15'h7fff, m[0]});
      repeat (3) @(negedge sys_clk);
      chk({15'h0000, multipin_oe_n}, {15'h0000, m[0] & m[1]});
      if (!(m[0] && m[1])) chk({15'h0000, multipin_out}, {15'h0000, m[0]});
      rd(OFF_GENERAL_PIN_DATA, {15'h0000, multipin_in});
    end
    $display("broadcast and pin test done");
    give_verdict;
  end
endmodule : test_bcp_regs
